// ---- mcsa_pkg.sv ----
// Purpose: constants and carriers for the motor command source arbiter
// Assumes: register writes arrive as decoded holding-register / coil strobes
// Notes:   register widths are 16 bits
package mcsa_pkg;
  localparam logic [15:0] PROFILE_ADDR   = 16'h006F;
  localparam logic [15:0] SOURCE_ADDR    = 16'h0073;
  localparam logic [15:0] COIL_ON1       = 16'h0001;
  localparam logic [15:0] COIL_ON2       = 16'h0002;
  localparam logic [15:0] COIL_LOCAL     = 16'h000A;
  localparam logic [15:0] COIL_REMOTE    = 16'h000B;
  localparam int          REM_LO         = 0;
  localparam int          CTL_LO         = 4;
  localparam int          TEL_LOCAL_BIT  = 9;
  localparam int          TEL_REMOTE_BIT = 10;
  localparam logic [2:0]  SRC_NONE       = 3'h0;
  localparam logic [2:0]  SRC_FIELDBUS   = 3'h1;
  localparam logic [2:0]  SRC_MODBUS     = 3'h2;
  localparam logic [2:0]  SRC_HARDWIRE   = 3'h3;
  localparam logic [2:0]  SEL_FIX_LOCAL  = 3'h4;
  localparam logic [2:0]  SEL_FIX_REMOTE = 3'h5;
  localparam logic [1:0]  PROT_FAULT     = 2'h3;
  localparam logic [1:0]  RESET_MAX_AUTO = 2'h3;
  localparam int          UNBAL_MS       = 500;
  localparam logic [3:0]  FAULT_PL_DLY   = 4'h0;
  localparam logic [15:0] SOURCE_RST     = 16'h0000;
  localparam logic [15:0] PROFILE_RST    = 16'h0000;

  typedef enum logic [1:0] {MCSA_SW_OFF, MCSA_SW_LOCAL, MCSA_SW_REMOTE} mcsa_sw_e;

  // per-source on/off command carrier
  typedef struct packed {
    logic on1;
    logic on2;
    logic off;
  } mcsa_cmd_s;

  // protection settings requested by software
  typedef struct packed {
    logic [1:0] overload;
    logic [1:0] thermistor;
    logic [1:0] phase_loss;
    logic [3:0] phase_loss_dly;
    logic [1:0] auto_reset;
    logic       unlimited_reset;
    logic       thermal_mem;
  } mcsa_prot_s;
endpackage : mcsa_pkg

// ---- mcsa_arbiter.sv ----
// Purpose: choose which command source may switch the contactors
// Assumes: modbus/tool/fieldbus frames decoded upstream into one-cycle strobes
// Notes:   contactor requests are held levels; protection outputs pass the request, forced only in explosive profile
`timescale 1ns/1ns
`default_nettype none
module mcsa_arbiter (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 mb_wr,
  input  wire logic [15:0]          mb_addr,
  input  wire logic [15:0]          mb_data,
  input  wire logic                 mb_coil_wr,
  input  wire logic [15:0]          mb_coil_addr,
  input  wire logic                 mb_coil_on,
  input  wire logic                 tool_wr,
  input  wire logic [15:0]          tool_addr,
  input  wire logic [15:0]          tool_data,
  input  wire logic                 fb_wr,
  input  wire logic [15:0]          fb_addr,
  input  wire logic [15:0]          fb_data,
  input  wire logic                 fb_enable,
  input  wire logic                 mb_enable,
  input  wire logic                 hw_enable,
  input  wire logic                 tool_enable,
  input  wire logic                 hw_two_bit,
  input  wire logic                 fb_two_bit,
  input  wire logic [15:0]          fieldbus_control_telegram,
  input  wire logic                 hw_sel_local,
  input  wire logic                 hw_sel_remote,
  input  wire mcsa_pkg::mcsa_cmd_s  hw_cmd,
  input  wire mcsa_pkg::mcsa_cmd_s  tool_cmd,
  input  wire mcsa_pkg::mcsa_prot_s prot_req,
  output logic [15:0]               source_select_q,
  output logic [15:0]               profile_select_q,
  output logic [1:0]                selector_pos,
  output logic                      first_contactor_on,
  output logic                      second_contactor_on,
  output mcsa_pkg::mcsa_prot_s      prot_eff,
  output logic                      explosive_mode,
  output logic                      redundancy_avail,
  output logic [9:0]                unbalance_dly_ms
);
  typedef struct packed {
    logic [15:0]          src;
    logic [15:0]          prof;
    mcsa_pkg::mcsa_sw_e   sw;
    logic                 on1;
    logic                 on2;
    logic [1:0]           mb_on;
    mcsa_pkg::mcsa_prot_s prot;
    logic                 fb_on1_q;
    logic                 fb_on2_q;
    logic                 atex_q;
    logic [9:0]           unbal_ms;
  } mcsa_state_s;

  mcsa_state_s st_r, st_nxt;
  logic [2:0]  rem, ctl;
  logic        loc_hw, loc_mb, loc_tool, rem_ok, loc_ok, atex;
  logic [2:0]  rem_wr;
  mcsa_pkg::mcsa_cmd_s grant;
  mcsa_pkg::mcsa_cmd_s mbc, fbc;

  assign rem  = st_r.src[mcsa_pkg::REM_LO +: 3];
  assign ctl  = st_r.src[mcsa_pkg::CTL_LO +: 3];
  assign atex = st_r.prof[1:0] != 2'h0;

  // local membership: enabled and not remote, modbus and tool dropped in fixed local 1-bit; fieldbus is never local
  always_comb begin
    loc_hw   = hw_enable && rem != mcsa_pkg::SRC_HARDWIRE;
    loc_mb   = mb_enable && rem != mcsa_pkg::SRC_MODBUS;
    loc_tool = tool_enable;
    if (ctl == mcsa_pkg::SEL_FIX_LOCAL && !hw_two_bit) begin
      loc_mb   = 1'b0;
      loc_tool = 1'b0;
    end
  end

  // who may issue commands right now
  always_comb begin
    rem_ok = 1'b0;
    loc_ok = 1'b0;
    unique case (ctl)
      mcsa_pkg::SEL_FIX_LOCAL:  loc_ok = 1'b1;
      mcsa_pkg::SEL_FIX_REMOTE: rem_ok = 1'b1;
      default: begin
        loc_ok = st_r.sw == mcsa_pkg::MCSA_SW_LOCAL;
        rem_ok = st_r.sw == mcsa_pkg::MCSA_SW_REMOTE;
      end
    endcase
  end

  // per-source commands: modbus coils latch, fieldbus 1-bit or 2-bit
  always_comb begin
    mbc.on1 = st_r.mb_on[0];
    mbc.on2 = st_r.mb_on[1];
    mbc.off = 1'b0;
    fbc.on1 = fieldbus_control_telegram[0];
    fbc.on2 = fieldbus_control_telegram[1];
    fbc.off = fb_two_bit && fieldbus_control_telegram[2];
    grant   = '0;
    if (loc_ok) begin
      if (loc_hw)   grant = grant | hw_cmd;
      if (loc_mb)   grant = grant | mbc;
      if (loc_tool) grant = grant | tool_cmd;
    end
    if (rem_ok) begin
      unique case (rem)
        mcsa_pkg::SRC_FIELDBUS: if (fb_enable) grant = fbc;
        mcsa_pkg::SRC_MODBUS:   if (mb_enable) grant = mbc;
        mcsa_pkg::SRC_HARDWIRE: if (hw_enable) grant = hw_cmd;
        default:                grant = '0;
      endcase
    end
  end

  // remote field of a proposed write; fieldbus enable pins it
  function automatic logic [2:0] fix_rem(input logic [2:0] r);
    if (fb_enable) fix_rem = mcsa_pkg::SRC_FIELDBUS;
    else if (r > mcsa_pkg::SRC_HARDWIRE) fix_rem = mcsa_pkg::SRC_NONE;
    else fix_rem = r;
  endfunction : fix_rem

  always_comb begin
    st_nxt = st_r;
    rem_wr = 3'h0;
    // selection register writes from modbus fn6 or tool
    if (mb_wr && mb_addr == mcsa_pkg::SOURCE_ADDR) begin
      rem_wr = fix_rem(mb_data[2:0]);
      st_nxt.src = {9'h000, (mb_data[6:4] > mcsa_pkg::SEL_FIX_REMOTE) ? 3'h0 : mb_data[6:4],
                    1'b0, rem_wr};
    end else if (tool_wr && tool_addr == mcsa_pkg::SOURCE_ADDR) begin
      rem_wr = fix_rem(tool_data[2:0]);
      st_nxt.src = {9'h000, (tool_data[6:4] > mcsa_pkg::SEL_FIX_REMOTE) ? 3'h0 : tool_data[6:4],
                    1'b0, rem_wr};
    end else if (fb_enable && rem != mcsa_pkg::SRC_FIELDBUS) begin
      st_nxt.src[2:0] = mcsa_pkg::SRC_FIELDBUS;
    end
    // explosive profile: modbus or tool only, fieldbus refused
    if (mb_wr && mb_addr == mcsa_pkg::PROFILE_ADDR)
      st_nxt.prof = {14'h0000, mb_data[1:0]};
    else if (tool_wr && tool_addr == mcsa_pkg::PROFILE_ADDR)
      st_nxt.prof = {14'h0000, tool_data[1:0]};
    // selector position, driven only by its configured controller
    unique case (ctl)
      mcsa_pkg::SRC_MODBUS:
        if (mb_coil_wr && mb_coil_on) begin
          if (mb_coil_addr == mcsa_pkg::COIL_LOCAL)  st_nxt.sw = mcsa_pkg::MCSA_SW_LOCAL;
          if (mb_coil_addr == mcsa_pkg::COIL_REMOTE) st_nxt.sw = mcsa_pkg::MCSA_SW_REMOTE;
        end
      mcsa_pkg::SRC_FIELDBUS:
        if (fieldbus_control_telegram[mcsa_pkg::TEL_LOCAL_BIT])
          st_nxt.sw = mcsa_pkg::MCSA_SW_LOCAL;
        else if (fieldbus_control_telegram[mcsa_pkg::TEL_REMOTE_BIT])
          st_nxt.sw = mcsa_pkg::MCSA_SW_REMOTE;
      mcsa_pkg::SRC_HARDWIRE:
        st_nxt.sw = hw_sel_local  ? mcsa_pkg::MCSA_SW_LOCAL :
                    hw_sel_remote ? mcsa_pkg::MCSA_SW_REMOTE : mcsa_pkg::MCSA_SW_OFF;
      default: st_nxt.sw = st_r.sw;
    endcase
    // modbus start coils are latched; coil off releases
    if (mb_coil_wr && mb_coil_addr == mcsa_pkg::COIL_ON1) st_nxt.mb_on[0] = mb_coil_on;
    if (mb_coil_wr && mb_coil_addr == mcsa_pkg::COIL_ON2) st_nxt.mb_on[1] = mb_coil_on;
    // contactor state: 1-bit follows level, 2-bit sets on and clears on off
    st_nxt.fb_on1_q = grant.on1;
    st_nxt.fb_on2_q = grant.on2;
    if (!loc_ok && !rem_ok) begin
      st_nxt.on1 = 1'b0;
      st_nxt.on2 = 1'b0;
    end else if (grant.off) begin
      st_nxt.on1 = 1'b0;
      st_nxt.on2 = 1'b0;
    end else if ((rem_ok && rem == mcsa_pkg::SRC_FIELDBUS) ? fb_two_bit : hw_two_bit) begin
      if (grant.on1) st_nxt.on1 = 1'b1;
      if (grant.on2) st_nxt.on2 = 1'b1;
    end else begin
      st_nxt.on1 = grant.on1;
      st_nxt.on2 = grant.on2;
    end
    // protection view, forced in explosive profile
    st_nxt.prot = prot_req;
    if (atex) begin
      st_nxt.prot.overload        = mcsa_pkg::PROT_FAULT;
      st_nxt.prot.thermistor      = mcsa_pkg::PROT_FAULT;
      st_nxt.prot.phase_loss      = mcsa_pkg::PROT_FAULT;
      st_nxt.prot.phase_loss_dly  = mcsa_pkg::FAULT_PL_DLY;
      st_nxt.prot.unlimited_reset = 1'b0;
      st_nxt.prot.thermal_mem     = 1'b1;
    end
    // flag and delay registered with the profile so outputs come from flops
    st_nxt.atex_q   = st_nxt.prof[1:0] != 2'h0;
    st_nxt.unbal_ms = st_nxt.atex_q ? 10'(mcsa_pkg::UNBAL_MS) : 10'h000;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.src  <= mcsa_pkg::SOURCE_RST;
      st_r.prof <= mcsa_pkg::PROFILE_RST;
      st_r.sw   <= mcsa_pkg::MCSA_SW_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flops
  assign source_select_q     = st_r.src;
  assign profile_select_q    = st_r.prof;
  assign selector_pos        = st_r.sw;
  assign first_contactor_on  = st_r.on1;
  assign second_contactor_on = st_r.on2;
  assign prot_eff            = st_r.prot;
  assign explosive_mode      = st_r.atex_q;
  assign redundancy_avail    = st_r.atex_q;
  assign unbalance_dly_ms    = st_r.unbal_ms;

  // checks
  fb_pins_rem_a: assert property (@(posedge core_clk) disable iff (rst)
    fb_enable ##1 fb_enable |=> st_r.src[2:0] == mcsa_pkg::SRC_FIELDBUS)
    else $error("fieldbus enabled but remote not fieldbus");
  rem_legal_a: assert property (@(posedge core_clk) disable iff (rst)
    st_r.src[2:0] <= mcsa_pkg::SRC_HARDWIRE)
    else $error("illegal remote code");
  write34_a: assert property (@(posedge core_clk) disable iff (rst)
    mb_wr && mb_addr == mcsa_pkg::SOURCE_ADDR && mb_data == 16'h0022 && !fb_enable
    |=> st_r.src[2:0] == mcsa_pkg::SRC_MODBUS && st_r.src[6:4] == mcsa_pkg::SRC_MODBUS)
    else $error("write of 34 not applied");
  fb_no_prof_a: assert property (@(posedge core_clk) disable iff (rst)
    !mb_wr && !tool_wr |=> $stable(st_r.prof))
    else $error("profile changed without modbus or tool");
  off_blocks_a: assert property (@(posedge core_clk) disable iff (rst)
    ctl < mcsa_pkg::SEL_FIX_LOCAL && st_r.sw == mcsa_pkg::MCSA_SW_OFF |=> !st_r.on1 && !st_r.on2)
    else $error("contactor on with selector off");
  atex_force_a: assert property (@(posedge core_clk) disable iff (rst)
    atex |=> st_r.prot.overload == mcsa_pkg::PROT_FAULT && st_r.prot.thermal_mem
             && !st_r.prot.unlimited_reset && st_r.prot.phase_loss_dly == 4'h0)
    else $error("explosive restrictions not applied");
  coil_remote_a: assert property (@(posedge core_clk) disable iff (rst)
    ctl == mcsa_pkg::SRC_MODBUS && mb_coil_wr && mb_coil_on && mb_coil_addr == mcsa_pkg::COIL_REMOTE
    |=> st_r.sw == mcsa_pkg::MCSA_SW_REMOTE)
    else $error("coil 11 did not select remote");
  fixloc_1bit_a: assert property (@(posedge core_clk) disable iff (rst)
    ctl == mcsa_pkg::SEL_FIX_LOCAL && !hw_two_bit |-> !loc_mb && !loc_tool)
    else $error("modbus or tool local in fixed local 1-bit");
  fixrem_a: assert property (@(posedge core_clk) disable iff (rst)
    ctl == mcsa_pkg::SEL_FIX_REMOTE |-> rem_ok && !loc_ok)
    else $error("fixed remote lets locals in");
  cv_remote_on: cover property (@(posedge core_clk) rem_ok && grant.on1 ##1 st_r.on1);
  cv_local_on: cover property (@(posedge core_clk) loc_ok && grant.on2 ##1 st_r.on2);
  cv_atex: cover property (@(posedge core_clk) $rose(atex));
endmodule : mcsa_arbiter
`default_nettype wire

// ---- mcsa_mb_master.sv ----
// Purpose: modbus rtu master model driving the decoded write strobes
// Assumes: caller enters just after a rising edge; strobe held for one edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module mcsa_mb_master (
  input  wire logic   core_clk,
  output logic        mb_wr,
  output logic [15:0] mb_addr,
  output logic [15:0] mb_data,
  output logic        mb_coil_wr,
  output logic [15:0] mb_coil_addr,
  output logic        mb_coil_on
);
  // idle bus at time zero
  initial begin
    mb_wr = 1'b0;
    mb_addr = 16'h0000;
    mb_data = 16'h0000;
    mb_coil_wr = 1'b0;
    mb_coil_addr = 16'h0000;
    mb_coil_on = 1'b0;
  end

  // function 6, single register write
  task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
    mb_addr = a;
    mb_data = d;
    mb_wr = 1'b1;
    @(posedge core_clk);
    #1;
    mb_wr = 1'b0;
    mb_addr = ~a; // stale values must not look valid
    mb_data = ~d;
  endtask : write_reg

  // function 5, single coil write
  task automatic write_coil(input logic [15:0] a, input logic on);
    mb_coil_addr = a;
    mb_coil_on = on;
    mb_coil_wr = 1'b1;
    @(posedge core_clk);
    #1;
    mb_coil_wr = 1'b0;
    mb_coil_addr = ~a;
    mb_coil_on = ~on;
  endtask : write_coil
endmodule : mcsa_mb_master
`default_nettype wire

// ---- motor_command_source_arbiter_tb.sv ----
// Purpose: self-checking bench for the command source arbiter
// Assumes: outputs settle one cycle after the taking edge
// Notes:   contactor checks wait a few cycles for the latch stage
`timescale 1ns/1ns
`default_nettype none
module motor_command_source_arbiter_tb;
  logic core_clk, rst, mb_wr, mb_coil_wr, mb_coil_on, tool_wr, fb_wr;
  logic fb_enable, mb_enable, hw_enable, tool_enable, hw_two_bit, fb_two_bit;
  logic hw_sel_local, hw_sel_remote, first_contactor_on, second_contactor_on;
  logic explosive_mode, redundancy_avail;
  logic [15:0] mb_addr, mb_data, mb_coil_addr, tool_addr, tool_data, fb_addr, fb_data;
  logic [15:0] fieldbus_control_telegram, source_select_q, profile_select_q;
  logic [1:0] selector_pos;
  logic [9:0] unbalance_dly_ms;
  mcsa_pkg::mcsa_cmd_s hw_cmd, tool_cmd;
  mcsa_pkg::mcsa_prot_s prot_req, prot_eff;
  int failures, tests_run;

  mcsa_mb_master u_mb (.core_clk, .mb_wr, .mb_addr, .mb_data, .mb_coil_wr,
    .mb_coil_addr, .mb_coil_on);
  mcsa_arbiter dut (.core_clk, .rst, .mb_wr, .mb_addr, .mb_data, .mb_coil_wr,
    .mb_coil_addr, .mb_coil_on, .tool_wr, .tool_addr, .tool_data, .fb_wr, .fb_addr,
    .fb_data, .fb_enable, .mb_enable, .hw_enable, .tool_enable, .hw_two_bit,
    .fb_two_bit, .fieldbus_control_telegram, .hw_sel_local, .hw_sel_remote, .hw_cmd,
    .tool_cmd, .prot_req, .source_select_q, .profile_select_q, .selector_pos,
    .first_contactor_on, .second_contactor_on, .prot_eff, .explosive_mode,
    .redundancy_avail, .unbalance_dly_ms);

  // free-running 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // verdict and the only end of the run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic t_select;
    u_mb.write_reg(mcsa_pkg::SOURCE_ADDR, 16'h0053);
    tick(1);
    chk(source_select_q, 16'h0053);
    u_mb.write_reg(mcsa_pkg::SOURCE_ADDR, 16'h0077);
    tick(1);
    chk(source_select_q, 16'h0000);
    u_mb.write_reg(mcsa_pkg::SOURCE_ADDR, 16'h0022);
    tick(1);
    chk(source_select_q, 16'h0022);
    $display("test select done");
  endtask : t_select

  task automatic t_remote_local;
    u_mb.write_coil(mcsa_pkg::COIL_REMOTE, 1'b1);
    tick(1);
    chk(16'(selector_pos), 16'h0002);
    u_mb.write_coil(mcsa_pkg::COIL_ON1, 1'b1);
    tool_cmd.on2 = 1'b1;
    tick(3);
    chk(16'(first_contactor_on), 16'h0001);
    chk(16'(second_contactor_on), 16'h0000);
    u_mb.write_coil(mcsa_pkg::COIL_ON1, 1'b0);
    tick(3);
    chk(16'(first_contactor_on), 16'h0000);
    u_mb.write_coil(mcsa_pkg::COIL_LOCAL, 1'b1);
    tick(3);
    chk(16'(selector_pos), 16'h0001);
    chk(16'(second_contactor_on), 16'h0001);
    fieldbus_control_telegram[mcsa_pkg::TEL_REMOTE_BIT] = 1'b1;
    tick(3);
    chk(16'(selector_pos), 16'h0001);
    tool_cmd = '0;
    fieldbus_control_telegram = 16'h0000;
    $display("test remote_local done");
  endtask : t_remote_local

  task automatic t_fixed_local;
    u_mb.write_reg(mcsa_pkg::SOURCE_ADDR, 16'h0043);
    tool_cmd.on1 = 1'b1;
    tick(3);
    chk(16'(first_contactor_on), 16'h0000);
    hw_two_bit = 1'b1;
    tick(3);
    chk(16'(first_contactor_on), 16'h0001);
    tool_cmd = 3'b001;
    tick(3);
    chk(16'(first_contactor_on), 16'h0000);
    tool_cmd = '0;
    $display("test fixed_local done");
  endtask : t_fixed_local

  task automatic t_explosive;
    fb_addr = mcsa_pkg::PROFILE_ADDR;
    fb_data = 16'h0001;
    fb_wr = 1'b1;
    tick(1);
    fb_wr = 1'b0;
    tick(1);
    chk(profile_select_q, 16'h0000);
    u_mb.write_reg(mcsa_pkg::PROFILE_ADDR, 16'h0001);
    tick(1);
    chk(profile_select_q, 16'h0001);
    chk(16'(explosive_mode), 16'h0001);
    chk(16'(prot_eff.overload), 16'(mcsa_pkg::PROT_FAULT));
    chk(16'(prot_eff.thermistor), 16'(mcsa_pkg::PROT_FAULT));
    chk(16'(prot_eff.phase_loss), 16'(mcsa_pkg::PROT_FAULT));
    chk(16'(prot_eff.phase_loss_dly), 16'(mcsa_pkg::FAULT_PL_DLY));
    chk(16'(unbalance_dly_ms), 16'd500);
    chk({14'h0000, prot_eff.unlimited_reset, prot_eff.thermal_mem}, 16'h0001);
    chk(16'(redundancy_avail), 16'h0001);
    $display("test explosive done");
  endtask : t_explosive

  // fieldbus controls the selector and drives the contactor in both styles
  task automatic t_fieldbus;
    u_mb.write_reg(mcsa_pkg::SOURCE_ADDR, 16'h0010);
    tick(1);
    chk(source_select_q, 16'h0011);
    fieldbus_control_telegram = 16'h0401;
    tick(3);
    chk(16'(selector_pos), 16'h0002);
    chk(16'(first_contactor_on), 16'h0001);
    fieldbus_control_telegram = 16'h0400;
    tick(3);
    chk(16'(first_contactor_on), 16'h0000);
    fb_two_bit = 1'b1;
    fieldbus_control_telegram = 16'h0401;
    tick(3);
    fieldbus_control_telegram = 16'h0400;
    tick(3);
    chk(16'(first_contactor_on), 16'h0001);
    fieldbus_control_telegram = 16'h0404;
    tick(3);
    chk(16'(first_contactor_on), 16'h0000);
    fieldbus_control_telegram = 16'h0000;
    $display("test fieldbus done");
  endtask : t_fieldbus

  // main sequence: reset, off selector, then scenarios
  initial begin
    {rst, tool_wr, fb_wr, fb_enable, hw_two_bit, fb_two_bit} = 6'h20;
    {mb_enable, hw_enable, tool_enable, hw_sel_local, hw_sel_remote} = 5'h1C;
    {tool_addr, tool_data, fb_addr, fb_data} = 64'h0000_0000_0000_0000;
    fieldbus_control_telegram = 16'h0000;
    {hw_cmd, tool_cmd} = 6'h00;
    prot_req = '{2'h1, 2'h0, 2'h1, 4'h5, 2'h2, 1'b1, 1'b0};
    failures = 0;
    tests_run = 0;
    tick(2);
    rst = 1'b0;
    hw_cmd.on1 = 1'b1;
    tick(3);
    chk(source_select_q, mcsa_pkg::SOURCE_RST);
    chk(16'(first_contactor_on), 16'h0000);
    hw_cmd = '0;
    t_select();
    t_remote_local();
    t_fixed_local();
    t_explosive();
    fb_enable = 1'b1;
    tick(2);
    chk(16'(source_select_q[2:0]), 16'(mcsa_pkg::SRC_FIELDBUS));
    t_fieldbus();
    final_report();
  end

  // watchdog for a hung run
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    final_report();
  end
endmodule : motor_command_source_arbiter_tb
`default_nettype wire
